// file: sces_pkg.sv
// package: constants and types for the serial channel event/status block
package sces_pkg;
  // wishbone byte offsets
  localparam logic [7:0] ADR_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] ADR_EVENT_MASK  = 8'h04;
  localparam logic [7:0] ADR_LINE_STATUS = 8'h08;
  localparam logic [7:0] ADR_MODE        = 8'h0C;
  localparam logic [7:0] ADR_BUSERR      = 8'h10;
  localparam logic [7:0] ADR_CONTROL     = 8'h14;
  // line_status fields
  localparam int LS_CTS  = 0;
  localparam int LS_CD   = 1;
  localparam int LS_IDLE = 2;
  // mode register fields
  localparam int MD_TXEN   = 0;
  localparam int MD_RXEN   = 1;
  localparam int MD_DIAG   = 2;
  localparam int MD_PROTO  = 4;
  localparam int MD_PHY    = 6;
  localparam int MD_DCHAN  = 8;
  localparam int MD_SWCTL  = 9;
  // control register fields
  localparam int CT_SYSIMR = 0;
  localparam int CT_CPRST  = 1;
  // event flag positions for status changes
  localparam int EV_CTS  = 5;
  localparam int EV_CD   = 6;
  localparam int EV_IDLE = 7;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [2:0] BUSERR_NONE = 3'h7;
  // idle thresholds in bit times
  localparam logic [4:0] HDLC_IDLE_BITS = 5'h0F;
  localparam logic [4:0] UART_IDLE_MIN  = 5'h09;
  localparam logic [4:0] UART_IDLE_MAX  = 5'h0D;
  // wishbone wait: ack one cycle after request taken
  localparam int WB_ACK_DELAY = 1;

  typedef enum logic [1:0] {
    SCES_DIAG_NORMAL = 2'h0,
    SCES_DIAG_LOOP   = 2'h1,
    SCES_DIAG_ECHO   = 2'h2,
    SCES_DIAG_SOFT   = 2'h3
  } sces_diag_t;

  typedef enum logic [1:0] {
    SCES_PROTO_HDLC = 2'h0,
    SCES_PROTO_UART = 2'h1,
    SCES_PROTO_OTHR = 2'h2,
    SCES_PROTO_RSVD = 2'h3
  } sces_proto_t;

  typedef enum logic [1:0] {
    SCES_PHY_NONMULTIPLEXED_INTERFACE = 2'h0,
    SCES_PHY_PCM  = 2'h1,
    SCES_PHY_MUX  = 2'h2,
    SCES_PHY_MUX2 = 2'h3
  } sces_phy_t;

  typedef struct packed {
    logic cts;
    logic cd;
    logic rxd;
  } sces_line_t;

  typedef struct packed {
    logic       err;
    logic [2:0] chan;
  } sces_dma_err_t;
endpackage

// file: sces_top.sv
// top: event flags, mask, line status and serial dma bus-error report
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// [R1] events set flags regardless of mask
// [R2] write one clears flag, zero keeps
// [R3] software avoids read-modify-write flag clearing
// [R4] flags clear on any reset source
// [R5] masked-in set flag raises pending bit
// [R6] interrupt also needs system mask enable
// [R7] eight-bit mask, same positions, reset zero
// [R8] pending clears when all unmasked flags clear
// [R9] read-only status, bits seven-three zero
// [R10] cts valid after tx enable, transmit_line_clock edges
// [R11] cd, idle valid after rx enable, rclk edges
// [R12] first enable flags a status change
// [R13] hdlc idle after fifteen ones
// [R14] uart idle after one idle character
// [R15] normal mode: no carrier forces idle
// [R16] software mode: idle follows line only
// [R17] cd same polarity, zero when multiplexed
// [R18] cts zero in pcm, d channel only
// [R19] software-controlled lines still report changes
// [R20] dma bus error interrupts, records channel
// [R21] processor restarted after dma bus error
// [R22] dma retry gives no status or interrupt
// [R23] line samples synchronised before use
module sces_top #(
  parameter int EVW = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cp_rst_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic [EVW-1:0] proto_event_i,
  input  wire logic        transmit_line_clock_i,
  input  wire logic        rclk_i,
  input  wire logic        cts_i,
  input  wire logic        cd_i,
  input  wire logic        rxd_i,
  input  wire logic        dma_berr_i,
  input  wire logic        dma_retry_i,
  input  wire logic [2:0]  dma_chan_i,
  output logic             chan_pending_o,
  output logic             chan_irq_o,
  output logic             berr_irq_o
);

  // two-flop synchronisers for pins, three-flop synchronisers for line clocks
  sces_pkg::sces_line_t line_m_q, line_s_q;
  logic [1:0] transmit_line_clock_m_q, rclk_m_q;
  logic transmit_line_clock_s_q, rclk_s_q, transmit_line_clock_p_q, rclk_p_q;

  always_ff @(posedge clk_i) begin
    line_m_q <= '{cts: cts_i, cd: cd_i, rxd: rxd_i};
    line_s_q <= line_m_q; // R23
    transmit_line_clock_m_q <= {transmit_line_clock_m_q[0], transmit_line_clock_i};
    rclk_m_q <= {rclk_m_q[0], rclk_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_line_clock_s_q <= 1'b0;
      rclk_s_q <= 1'b0;
      transmit_line_clock_p_q <= 1'b0;
      rclk_p_q <= 1'b0;
    end else begin
      transmit_line_clock_s_q <= transmit_line_clock_m_q[1];
      rclk_s_q <= rclk_m_q[1];
      transmit_line_clock_p_q <= transmit_line_clock_s_q;
      rclk_p_q <= rclk_s_q;
    end
  end

  wire transmit_line_clock_rise = transmit_line_clock_s_q & ~transmit_line_clock_p_q; // R10
  wire rclk_rise = rclk_s_q & ~rclk_p_q; // R11

  // registers
  logic [EVW-1:0] flags_q, mask_q;
  logic [9:0]  mode_q;
  logic [1:0]  ctrl_q;
  logic        any_rst;
  assign any_rst = rst_i | cp_rst_i | ctrl_q[sces_pkg::CT_CPRST]; // R4

  wire txen = mode_q[sces_pkg::MD_TXEN];
  wire rxen = mode_q[sces_pkg::MD_RXEN];
  sces_pkg::sces_diag_t  diag;
  sces_pkg::sces_proto_t proto;
  sces_pkg::sces_phy_t   phy;
  assign diag  = sces_pkg::sces_diag_t'(mode_q[sces_pkg::MD_DIAG +: 2]);
  assign proto = sces_pkg::sces_proto_t'(mode_q[sces_pkg::MD_PROTO +: 2]);
  assign phy   = sces_pkg::sces_phy_t'(mode_q[sces_pkg::MD_PHY +: 2]);

  // wishbone decode; ack one cycle after the request is seen
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  wire [7:0] wb_off = wb_adr_i[7:0];

  // cts sampling on transmit_line_clock edges, cd/rxd on rclk edges
  logic cts_q, cd_q, idle_q;
  logic [4:0] ones_q, ones_nx;
  logic cts_seen_q, rx_seen_q;
  logic mux_phy;
  assign mux_phy = (phy == sces_pkg::SCES_PHY_MUX) | (phy == sces_pkg::SCES_PHY_MUX2);

  logic cts_eff, cd_eff;
  always_comb begin
    cts_eff = line_s_q.cts; // R19
    if (phy == sces_pkg::SCES_PHY_PCM)
      cts_eff = 1'b0; // R18
    else if (mux_phy && !mode_q[sces_pkg::MD_DCHAN])
      cts_eff = 1'b0; // R18
    cd_eff = mux_phy ? 1'b0 : line_s_q.cd; // R17
  end

  // line ones counter: rxd high counts bit times
  // idle judged on the count including the bit sampled now, else it lags one bit
  always_comb begin
    ones_nx = ones_q;
    if (!line_s_q.rxd)
      ones_nx = 5'h00; // R13 R14
    else if (ones_q != sces_pkg::UART_IDLE_MAX + 5'h02)
      ones_nx = ones_q + 5'h01;
  end

  logic line_idle;
  always_comb begin
    case (proto)
      sces_pkg::SCES_PROTO_HDLC: line_idle = (ones_nx >= sces_pkg::HDLC_IDLE_BITS); // R13
      sces_pkg::SCES_PROTO_UART: line_idle = (ones_nx >= sces_pkg::UART_IDLE_MIN); // R14
      default:                   line_idle = 1'b0;
    endcase
  end

  logic idle_eff;
  always_comb begin
    idle_eff = line_idle; // R16
    if (diag == sces_pkg::SCES_DIAG_NORMAL && !cd_eff)
      idle_eff = 1'b1; // R15
  end

  always_ff @(posedge clk_i) begin
    if (any_rst)
      ones_q <= 5'h00;
    else if (rclk_rise && rxen)
      ones_q <= ones_nx;
  end

  logic cts_chg, cd_chg, idle_chg;
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      cts_q      <= 1'b0;
      cd_q       <= 1'b0;
      idle_q     <= 1'b0;
      cts_seen_q <= 1'b0;
      rx_seen_q  <= 1'b0;
      cts_chg    <= 1'b0;
      cd_chg     <= 1'b0;
      idle_chg   <= 1'b0;
    end else begin
      cts_chg  <= 1'b0;
      cd_chg   <= 1'b0;
      idle_chg <= 1'b0;
      if (txen && transmit_line_clock_rise) begin
        cts_seen_q <= 1'b1;
        if (!cts_seen_q || cts_eff != cts_q) begin
          cts_q   <= cts_eff; // R10
          cts_chg <= 1'b1; // R12
        end
      end
      if (rxen && rclk_rise) begin
        rx_seen_q <= 1'b1;
        if (!rx_seen_q || cd_eff != cd_q) begin
          cd_q   <= cd_eff; // R11
          cd_chg <= 1'b1; // R12
        end
        if (!rx_seen_q || idle_eff != idle_q) begin
          idle_q   <= idle_eff; // R11
          idle_chg <= 1'b1; // R12
        end
      end
    end
  end

  // event flags: set beats clear
  logic [EVW-1:0] set_vec;
  always_comb begin
    set_vec = proto_event_i; // R1
    set_vec[sces_pkg::EV_CTS]  = set_vec[sces_pkg::EV_CTS] | cts_chg;
    set_vec[sces_pkg::EV_CD]   = set_vec[sces_pkg::EV_CD] | cd_chg;
    set_vec[sces_pkg::EV_IDLE] = set_vec[sces_pkg::EV_IDLE] | idle_chg;
  end

  always_ff @(posedge clk_i) begin
    if (any_rst)
      flags_q <= sces_pkg::FLAGS_RST; // R4
    else if (wb_wr && wb_off == sces_pkg::ADR_EVENT_FLAGS)
      flags_q <= (flags_q & ~wb_dat_i[EVW-1:0]) | set_vec; // R2
    else
      flags_q <= flags_q | set_vec; // R1
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= sces_pkg::MASK_RST; // R7
      mode_q <= 10'h000;
      ctrl_q <= 2'h0;
    end else begin
      ctrl_q[sces_pkg::CT_CPRST] <= 1'b0;
      if (wb_wr && wb_off == sces_pkg::ADR_EVENT_MASK)
        mask_q <= wb_dat_i[EVW-1:0]; // R7
      if (wb_wr && wb_off == sces_pkg::ADR_MODE)
        mode_q <= wb_dat_i[9:0];
      if (wb_wr && wb_off == sces_pkg::ADR_CONTROL)
        ctrl_q <= wb_dat_i[1:0]; // R21
    end
  end

  // serial dma bus error: retries are ignored
  sces_pkg::sces_dma_err_t berr_q;
  always_ff @(posedge clk_i) begin
    if (any_rst)
      berr_q <= '{err: 1'b0, chan: sces_pkg::BUSERR_NONE};
    else if (dma_berr_i && !dma_retry_i && !berr_q.err)
      berr_q <= '{err: 1'b1, chan: dma_chan_i}; // R20 R22
  end

  // interrupt outputs, registered
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      chan_pending_o <= 1'b0;
      chan_irq_o     <= 1'b0;
      berr_irq_o     <= 1'b0;
    end else begin
      chan_pending_o <= |(flags_q & mask_q); // R5 R8
      chan_irq_o     <= (|(flags_q & mask_q)) & ctrl_q[sces_pkg::CT_SYSIMR]; // R6
      berr_irq_o     <= berr_q.err; // R20
    end
  end

  // read mux; unmapped reads return zero with ack
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_off)
      sces_pkg::ADR_EVENT_FLAGS: rd[EVW-1:0] = flags_q;
      sces_pkg::ADR_EVENT_MASK:  rd[EVW-1:0] = mask_q;
      sces_pkg::ADR_LINE_STATUS: begin
        rd[sces_pkg::LS_CTS]  = cts_q; // R9
        rd[sces_pkg::LS_CD]   = cd_q;
        rd[sces_pkg::LS_IDLE] = idle_q;
      end
      sces_pkg::ADR_MODE:    rd[9:0] = mode_q;
      sces_pkg::ADR_BUSERR:  rd[3:0] = berr_q;
      sces_pkg::ADR_CONTROL: rd[1:0] = ctrl_q;
      default:               rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd : 32'h0000_0000;
    end
  end

endmodule // sces_top

// file: sces_top_assertions.sv
// checker: port-level assertions for the event and line-status block
`timescale 1ns/100ps
module sces_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cp_rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        dma_berr_i,
  input wire logic        dma_retry_i,
  input wire logic        chan_pending_o,
  input wire logic        chan_irq_o,
  input wire logic        berr_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  chk_irq_pend: assert property (chan_irq_o |-> chan_pending_o || $past(chan_pending_o))
    else $error("interrupt without pending bit");
  // the wait covers the write's own edge, the flag update and the pending flop
  chk_pend_fall: assert property ($fell(chan_pending_o) |->
    $past(wb_cyc_i) || $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3) || $past(cp_rst_i))
    else $error("pending fell without a clear");
  chk_berr_set: assert property (dma_berr_i && !dma_retry_i && !cp_rst_i |=> ##1 berr_irq_o)
    else $error("bus error not reported");
  chk_retry_quiet: assert property (dma_berr_i && dma_retry_i && !berr_irq_o |=> !berr_irq_o)
    else $error("retry raised bus error");
  chk_berr_hold: assert property (
    berr_irq_o && !cp_rst_i && !wb_cyc_i && !$past(wb_cyc_i) |=> berr_irq_o)
    else $error("bus error report dropped");
  chk_cprst_clr: assert property (cp_rst_i |=> !berr_irq_o && !chan_irq_o)
    else $error("processor reset left outputs set");
  cover property (wb_ack_o && wb_we_i);
  cover property (chan_irq_o);
  cover property (berr_irq_o);
endmodule // sces_chk
bind sces_top sces_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cp_rst_i(cp_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .dma_berr_i(dma_berr_i), .dma_retry_i(dma_retry_i),
  .chan_pending_o(chan_pending_o), .chan_irq_o(chan_irq_o), .berr_irq_o(berr_irq_o));

// file: sces_line_model.sv
// far-end line model: line clock bursts, modem levels and receive data
`timescale 1ns/100ps
module sces_line_model (
  output logic lclk_o,
  output logic cts_o,
  output logic cd_o,
  output logic rxd_o
);
  initial begin
    lclk_o = 1'b0;
    cts_o = 1'b0;
    cd_o = 1'b0;
    rxd_o = 1'b0;
  end
  task automatic lvl(input logic c, input logic d);
    cts_o = c;
    cd_o = d;
  endtask
  // clock stands still between bursts; data flips so a stale level is never trusted
  task automatic burst(input logic b, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o = b;
      #32 lclk_o = 1'b1;
      #32 lclk_o = 1'b0;
    end
    rxd_o = ~b;
  endtask
endmodule // sces_line_model

// file: serial_channel_event_status_test.sv
// testbench: registers, events, line status and bus-error report
`timescale 1ns/100ps
module serial_channel_event_status_test;
  localparam logic [7:0] AF = sces_pkg::ADR_EVENT_FLAGS;
  localparam logic [7:0] AM = sces_pkg::ADR_EVENT_MASK;
  localparam logic [7:0] AS = sces_pkg::ADR_LINE_STATUS;
  localparam logic [7:0] AD = sces_pkg::ADR_MODE;
  localparam logic [7:0] AB = sces_pkg::ADR_BUSERR;
  localparam logic [7:0] AC = sces_pkg::ADR_CONTROL;
  logic        clk_i = 1'b0, rst_i = 1'b1, cp_rst_i = 1'b0;
  logic [31:0] wb_adr_i = '0, wb_dat_i = '0, rdat;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0]  ev = '0;
  logic        berr = 1'b0, retry = 1'b0;
  logic [2:0]  chan = '0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, pend, irq, berr_irq, lclk, cts, cd, rxd;
  int          failures = 0, n_compared = 0;
  sces_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cp_rst_i(cp_rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hF),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .proto_event_i(ev),
    .transmit_line_clock_i(lclk), .rclk_i(lclk), .cts_i(cts), .cd_i(cd), .rxd_i(rxd), .dma_berr_i(berr),
    .dma_retry_i(retry), .dma_chan_i(chan), .chan_pending_o(pend), .chan_irq_o(irq),
    .berr_irq_o(berr_irq));
  sces_line_model line (.lclk_o(lclk), .cts_o(cts), .cd_o(cd), .rxd_o(rxd));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_reg({31'h0, got}, {31'h0, exp});
  endtask
  // bus cycle; holds the request until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (t >= 20) failures++;
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, '0);
    cmp_reg(rdat, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // line samples need a few cycles to cross into the register clock
  task automatic ln(input logic b, input int n);
    line.burst(b, n);
    wt(8);
  endtask
  task automatic t_regs;
    chk(AF, 8'h00);
    chk(AM, 8'h00);
    chk(8'h3C, 8'h00);
    xfer(1'b1, AM, 8'hA5);
    chk(AM, 8'hA5);
    xfer(1'b1, AS, 8'hFF);
    chk(AS, 8'h00);
    xfer(1'b1, AM, 8'h00);
  endtask
  task automatic t_events;
    ev <= 8'h09;
    wt(1);
    ev <= 8'h00;
    wt(2);
    chk(AF, 8'h09);
    cmp_bit(pend, 1'b0);
    xfer(1'b1, AF, 8'h01);
    chk(AF, 8'h08);
    ev <= 8'h01;
    wt(1);
    ev <= 8'h00;
    xfer(1'b1, AM, 8'h09);
    wt(2);
    cmp_bit(pend, 1'b1);
    cmp_bit(irq, 1'b0);
    xfer(1'b1, AC, 8'h01);
    wt(2);
    cmp_bit(irq, 1'b1);
    xfer(1'b1, AF, 8'h01);
    wt(2);
    cmp_bit(pend, 1'b1);
    xfer(1'b1, AF, 8'h08);
    wt(2);
    cmp_bit(pend, 1'b0);
    cmp_bit(irq, 1'b0);
    ev <= 8'hFF;
    cp_rst_i <= 1'b1;
    wt(1);
    ev <= 8'h00;
    cp_rst_i <= 1'b0;
    wt(2);
    chk(AF, 8'h00);
  endtask
  task automatic t_line;
    logic [9:0] md [3] = '{10'h29F, 10'h39F, 10'h25F};
    logic [7:0] ex [3] = '{8'h04, 8'h05, 8'h06};
    line.lvl(1'b1, 1'b1);
    xfer(1'b1, AD, 10'h20F);
    ln(1'b1, 14);
    chk(AS, 8'h03);
    xfer(1'b0, AF, '0);
    cmp_reg(rdat & 8'hE0, 8'hE0);
    xfer(1'b1, AF, 8'hFF);
    ln(1'b1, 1);
    chk(AS, 8'h07);
    ln(1'b0, 1);
    chk(AS, 8'h03);
    chk(AF, 8'h80);
    xfer(1'b1, AF, 8'hFF);
    line.lvl(1'b0, 1'b1);
    wt(8);
    chk(AS, 8'h03);
    ln(1'b1, 1);
    chk(AS, 8'h02);
    chk(AF, 8'h20);
    line.lvl(1'b1, 1'b1);
    xfer(1'b1, AD, 10'h21F);
    ln(1'b0, 1);
    ln(1'b1, 8);
    chk(AS, 8'h03);
    ln(1'b1, 1);
    chk(AS, 8'h07);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, AD, md[i]);
      ln(1'b1, 1);
      chk(AS, ex[i]);
    end
    line.lvl(1'b1, 1'b0);
    xfer(1'b1, AD, 10'h203);
    ln(1'b0, 1);
    chk(AS, 8'h05);
  endtask
  task automatic t_berr;
    chan <= 3'h3;
    retry <= 1'b1;
    berr <= 1'b1;
    wt(1);
    retry <= 1'b0;
    berr <= 1'b0;
    wt(2);
    cmp_bit(berr_irq, 1'b0);
    chk(AB, 8'h07);
    berr <= 1'b1;
    wt(1);
    chan <= 3'h5;
    wt(1);
    berr <= 1'b0;
    wt(2);
    cmp_bit(berr_irq, 1'b1);
    chk(AB, 8'h0B);
    xfer(1'b1, AC, 8'h02);
    wt(2);
    cmp_bit(berr_irq, 1'b0);
    chk(AB, 8'h07);
  endtask
  initial begin
    wt(5);
    rst_i <= 1'b0;
    wt(1);
    t_regs();
    t_events();
    t_line();
    t_berr();
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule // serial_channel_event_status_test
